// ---- scse_pkg.sv ----
// Purpose: Shared constants and types of the SPI step sequencer
// Assumes: 20 MHz core clock, delay steps counted in milliseconds
// Notes:   Opcodes are the binary codes of the step port
package scse_pkg;

  // Core clock and delay timing
  localparam int unsigned CLOCK_HZ        = 20_000_000;
  localparam int unsigned DELAY_UNIT_MS   = 1;
  localparam int unsigned MS_CYCLES       = CLOCK_HZ / 1000 * DELAY_UNIT_MS;

  // Step field widths
  localparam int unsigned OP_W            = 4;
  localparam int unsigned PARAM_A_W       = 16;
  localparam int unsigned PARAM_B_W       = 8;
  localparam int unsigned STEP_W          = OP_W + PARAM_A_W + PARAM_B_W;
  localparam int unsigned STEP_DEPTH      = 32;
  localparam int unsigned FIFO_DEPTH      = 32;

  // Scratch buffer
  localparam int unsigned SCRATCH_BYTES   = 16;
  localparam logic [16:0] SCRATCH_LIMIT   = 17'h0_0010;
  localparam logic [15:0] INDEX_LIMIT     = 16'h000F;
  localparam logic [7:0]  SCRATCH_RESET   = 8'h00;

  // Filler byte shifted out while reading
  localparam logic [7:0]  DUMMY_BYTE      = 8'hFF;

  // Typical flash commands carried in byte lists
  localparam logic [7:0]  CMD_WRITE_EN    = 8'h06;
  localparam logic [7:0]  CMD_SEC_ERASE   = 8'h44;
  localparam logic [7:0]  CMD_SEC_PROGRAM = 8'h42;
  localparam logic [7:0]  CMD_SEC_READ    = 8'h48;

  // Link shifter: four link clocks per bit
  localparam logic [1:0]  PH_RISE         = 2'h0;
  localparam logic [1:0]  PH_FALL         = 2'h2;
  localparam logic [1:0]  PH_SAMPLE       = 2'h3;
  localparam logic [2:0]  LAST_BIT        = 3'h7;

  typedef enum logic [OP_W-1:0] {
    OP_DELAY, OP_CS_ON, OP_CS_OFF, OP_WRITE, OP_VREAD,
    OP_VWRITE, OP_VAND, OP_VOR, OP_VXOR
  } scse_op_e;

  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_EXEC, S_XFER, S_DELAY, S_NEXT
  } scse_state_e;

endpackage : scse_pkg

// ---- scse_engine.sv ----
// Purpose: Runs init and exit step lists against a serial flash
// Assumes: Steps loaded through the step port before a start pulse
// Notes:   SPI shifter runs on link_clock; toggle handshake crosses
`timescale 1ns/10ps
`default_nettype none

module scse_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) ||
                     (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : scse_fifo

module scse_engine
  import scse_pkg::*;
#(
  parameter int unsigned DEPTH      = STEP_DEPTH,
  parameter int unsigned LIST_DEPTH = FIFO_DEPTH,
  parameter int unsigned MS_COUNT   = MS_CYCLES
) (
  // Core clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // Link clock
  input  wire logic                 link_clock,
  // Step list loading
  input  wire logic                 step_wr_en,
  input  wire logic                 step_wr_list,
  input  wire logic [$clog2(DEPTH)-1:0] step_wr_index,
  input  wire logic [OP_W-1:0]      step_wr_op,
  input  wire logic [PARAM_A_W-1:0] step_param_a,
  input  wire logic [PARAM_B_W-1:0] step_param_b,
  input  wire logic [$clog2(DEPTH):0] init_step_count,
  input  wire logic [$clog2(DEPTH):0] exit_step_count,
  // Byte list stream
  input  wire logic                 byte_list_valid,
  output logic                      byte_list_ready,
  input  wire logic [7:0]           byte_list_data,
  // Sequence control
  input  wire logic                 start_init,
  input  wire logic                 start_exit,
  input  wire logic                 programming_done,
  output logic                      busy,
  output logic                      done,
  output logic                      error,
  // Scratch readback
  input  wire logic [3:0]           buffer_byte_index,
  output logic      [7:0]           scratch_rd_data,
  // SPI pins
  output logic                      spi_cs_n,
  output logic                      spi_sck,
  output logic                      spi_mosi,
  input  wire logic                 spi_miso
);
  localparam int unsigned IW = $clog2(DEPTH);

  logic [STEP_W-1:0]    steps [2*DEPTH];
  logic [7:0]           scratch [SCRATCH_BYTES];
  scse_state_e          state;
  scse_op_e             cur_op;
  logic [PARAM_A_W-1:0] cur_a;
  logic [PARAM_B_W-1:0] cur_b;
  logic                 list_sel;
  logic [IW:0]          step_idx;
  logic [IW:0]          cur_len;
  logic [STEP_W-1:0]    step_word;
  logic [15:0]          cnt;
  logic [15:0]          ms_left;
  logic [31:0]          tick;
  logic [3:0]           ptr;
  logic [7:0]           logic_result;
  logic                 range_bad;
  logic                 launch;
  logic                 pop;
  logic [7:0]           tx_byte;
  logic                 req_tgl;
  logic                 ack_s1;
  logic                 ack_s2;
  logic                 ack_seen;
  logic                 ack_new;
  logic                 fifo_valid;
  logic [7:0]           fifo_data;
  // Link domain
  logic                 rst_l1;
  logic                 rst_l2;
  logic                 req_l1;
  logic                 req_l2;
  logic                 req_seen;
  logic                 miso_l1;
  logic                 miso_l2;
  logic                 active;
  logic [1:0]           phase;
  logic [2:0]           bitn;
  logic [7:0]           shreg;
  logic [7:0]           rx_byte;
  logic                 ack_tgl;

  scse_fifo #(.WIDTH(8), .DEPTH(LIST_DEPTH)) u_list_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (byte_list_valid),
    .in_ready  (byte_list_ready),
    .in_data   (byte_list_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  always_ff @(posedge clock) begin
    if (step_wr_en) begin
      steps[{step_wr_list, step_wr_index}] <=
        {step_wr_op, step_param_a, step_param_b};
    end
  end

  assign step_word = steps[{list_sel, step_idx[IW-1:0]}];
  assign cur_len   = list_sel ? exit_step_count : init_step_count;
  assign ptr       = cur_a[3:0] + cnt[3:0];
  assign busy      = (state != S_IDLE);
  assign ack_new   = (ack_s2 != ack_seen);

  // Range check of offset plus count, or of a byte index
  always_comb begin
    range_bad = 1'b0;
    if (cur_op == OP_VREAD || cur_op == OP_VWRITE) begin
      range_bad = ({1'b0, cur_a} + {9'h000, cur_b}) > SCRATCH_LIMIT;
    end else if (cur_op == OP_VAND || cur_op == OP_VOR ||
                 cur_op == OP_VXOR) begin
      range_bad = cur_a > INDEX_LIMIT;
    end
  end

  always_comb begin
    logic_result = scratch[cur_a[3:0]];
    unique case (cur_op)
      OP_VAND: logic_result = scratch[cur_a[3:0]] & cur_b;
      OP_VOR:  logic_result = scratch[cur_a[3:0]] | cur_b;
      OP_VXOR: logic_result = scratch[cur_a[3:0]] ^ cur_b;
      default: logic_result = scratch[cur_a[3:0]];
    endcase
  end

  // Launch of one SPI byte; byte lists carry the flash commands
  always_comb begin
    launch = 1'b0;
    pop    = 1'b0;
    if (state == S_EXEC) begin
      if (cur_op == OP_WRITE && cnt != cur_a) begin
        launch = fifo_valid;
        pop    = fifo_valid;
      end else if ((cur_op == OP_VREAD || cur_op == OP_VWRITE) &&
                   !range_bad && cnt != {8'h00, cur_b}) begin
        launch = 1'b1;
      end
    end
  end

  // Step sequencer
  always_ff @(posedge clock) begin
    if (reset) begin
      state    <= S_IDLE;
      list_sel <= 1'b0;
      step_idx <= '0;
      cur_op   <= OP_DELAY;
      cur_a    <= '0;
      cur_b    <= '0;
      cnt      <= '0;
      ms_left  <= '0;
      tick     <= '0;
      done     <= 1'b0;
      error    <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (start_init) begin
            list_sel <= 1'b0;
            step_idx <= '0;
            error    <= 1'b0;
            state    <= S_FETCH;
          end else if (start_exit && programming_done) begin
            list_sel <= 1'b1;
            step_idx <= '0;
            error    <= 1'b0;
            state    <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (step_idx == cur_len) begin
            done  <= 1'b1;
            state <= S_IDLE;
          end else begin
            cur_op <= scse_op_e'(step_word[STEP_W-1 -: OP_W]);
            cur_a  <= step_word[PARAM_B_W +: PARAM_A_W];
            cur_b  <= step_word[PARAM_B_W-1:0];
            cnt    <= '0;
            state  <= S_EXEC;
          end
        end
        S_EXEC: begin
          unique case (cur_op)
            OP_DELAY: begin
              ms_left <= cur_a;
              tick    <= '0;
              state   <= S_DELAY;
            end
            OP_CS_ON, OP_CS_OFF: state <= S_NEXT;
            OP_WRITE: begin
              if (cnt == cur_a) begin
                state <= S_NEXT;
              end else if (launch) begin
                state <= S_XFER;
              end
            end
            OP_VREAD, OP_VWRITE, OP_VAND, OP_VOR, OP_VXOR: begin
              if (range_bad) begin
                error <= 1'b1;
                done  <= 1'b1;
                state <= S_IDLE;
              end else if (launch) begin
                state <= S_XFER;
              end else begin
                state <= S_NEXT;
              end
            end
            default: begin
              error <= 1'b1;
              done  <= 1'b1;
              state <= S_IDLE;
            end
          endcase
        end
        S_XFER: begin
          if (ack_new) begin
            cnt   <= cnt + 16'h0001;
            state <= S_EXEC;
          end
        end
        S_DELAY: begin
          if (ms_left == 16'h0000) begin
            state <= S_NEXT;
          end else if (tick == MS_COUNT - 1) begin
            tick    <= '0;
            ms_left <= ms_left - 16'h0001;
          end else begin
            tick <= tick + 32'h0000_0001;
          end
        end
        S_NEXT: begin
          step_idx <= step_idx + 1'b1;
          state    <= S_FETCH;
        end
      endcase
    end
  end

  // Chip select; forced high when a step fails its range check, left as is on an illegal opcode abort
  always_ff @(posedge clock) begin
    if (reset) begin
      spi_cs_n <= 1'b1;
    end else if (state == S_EXEC && cur_op == OP_CS_ON) begin
      spi_cs_n <= 1'b0;
    end else if (state == S_EXEC && (cur_op == OP_CS_OFF || range_bad)) begin
      spi_cs_n <= 1'b1;
    end
  end

  // Scratch buffer updates
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < SCRATCH_BYTES; i++) begin
        scratch[i] <= SCRATCH_RESET;
      end
    end else if (state == S_XFER && ack_new && cur_op == OP_VREAD) begin
      scratch[ptr] <= rx_byte;
    end else if (state == S_EXEC && !range_bad &&
                 (cur_op == OP_VAND || cur_op == OP_VOR ||
                  cur_op == OP_VXOR)) begin
      scratch[cur_a[3:0]] <= logic_result;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      scratch_rd_data <= SCRATCH_RESET;
    end else begin
      scratch_rd_data <= scratch[buffer_byte_index];
    end
  end

  // Request toggle with held byte towards the link
  always_ff @(posedge clock) begin
    if (reset) begin
      req_tgl <= 1'b0;
      tx_byte <= '0;
    end else if (launch) begin
      req_tgl <= ~req_tgl;
      if (cur_op == OP_WRITE) begin
        tx_byte <= fifo_data;
      end else if (cur_op == OP_VREAD) begin
        tx_byte <= DUMMY_BYTE;
      end else begin
        tx_byte <= scratch[ptr];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ack_s1   <= 1'b0;
      ack_s2   <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      ack_s1   <= ack_tgl;
      ack_s2   <= ack_s1;
      ack_seen <= ack_s2;
    end
  end

  // Link domain: reset and input synchronisers
  always_ff @(posedge link_clock) begin
    rst_l1  <= reset;
    rst_l2  <= rst_l1;
    req_l1  <= req_tgl;
    req_l2  <= req_l1;
    miso_l1 <= spi_miso;
    miso_l2 <= miso_l1;
  end

  // Mode 0 shifter, MSB first, four link clocks per bit
  always_ff @(posedge link_clock) begin
    if (rst_l2) begin
      active   <= 1'b0;
      req_seen <= 1'b0;
      ack_tgl  <= 1'b0;
      spi_sck  <= 1'b0;
      spi_mosi <= 1'b0;
      shreg    <= '0;
      rx_byte  <= '0;
      bitn     <= '0;
      phase    <= '0;
    end else if (!active) begin
      if (req_l2 != req_seen) begin
        req_seen <= req_l2;
        shreg    <= tx_byte;
        spi_mosi <= tx_byte[7];
        active   <= 1'b1;
        bitn     <= '0;
        phase    <= '0;
      end
    end else begin
      phase <= phase + 2'h1;
      if (phase == PH_RISE) begin
        spi_sck <= 1'b1;
      end else if (phase == PH_FALL) begin
        spi_sck <= 1'b0;
      end else if (phase == PH_SAMPLE) begin
        shreg <= {shreg[6:0], miso_l2};
        if (bitn == LAST_BIT) begin
          active  <= 1'b0;
          rx_byte <= {shreg[6:0], miso_l2};
          ack_tgl <= ~ack_tgl;
        end else begin
          bitn     <= bitn + 3'h1;
          spi_mosi <= shreg[6];
        end
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_cs_on;  state == S_EXEC && cur_op == OP_CS_ON;  endsequence
  sequence s_cs_off; state == S_EXEC && cur_op == OP_CS_OFF; endsequence
  sequence s_read_ack;
    state == S_XFER && ack_new && cur_op == OP_VREAD;
  endsequence

  a_cs_goes_low: assert property (s_cs_on |=> !spi_cs_n)
    else $error("chip select not low after assert step");
  a_cs_goes_high: assert property (s_cs_off |=> spi_cs_n)
    else $error("chip select not high after deassert step");
  a_write_pop_bound: assert property (
    pop |-> cur_op == OP_WRITE && cnt < cur_a)
    else $error("byte list popped beyond count");
  a_delay_holds: assert property (
    state == S_DELAY && ms_left != 16'h0000 |=> state == S_DELAY)
    else $error("delay left early");
  a_read_advances: assert property (
    s_read_ack |=> cnt == $past(cnt) + 16'h0001 &&
                   scratch[$past(ptr)] == $past(rx_byte))
    else $error("read byte not stored");
  a_vwrite_source: assert property (
    launch && cur_op == OP_VWRITE |=> tx_byte == $past(scratch[ptr]))
    else $error("buffer write byte wrong");
  a_logic_op_apply: assert property (
    state == S_EXEC && !range_bad &&
    (cur_op == OP_VAND || cur_op == OP_VOR || cur_op == OP_VXOR)
    |=> scratch[$past(cur_a[3:0])] == $past(logic_result))
    else $error("logic op result wrong");
  a_exit_gated: assert property (
    state == S_IDLE && !start_init && !programming_done |=> state == S_IDLE)
    else $error("exit list started before programming done");
  a_xfer_waits: assert property (
    state == S_XFER && !ack_new |=> state == S_XFER)
    else $error("step moved on before byte finished");
  a_range_error: assert property (
    state == S_EXEC && range_bad |=> error && done && spi_cs_n &&
                                     state == S_IDLE)
    else $error("out of range step not rejected");

endmodule : scse_engine

`default_nettype wire

// ---- scse_flash_model.sv ----
// Purpose: Behavioural serial flash on the far side of the SPI link
// Assumes: Mode 0, MSB first, read data base + byte position in frame
// Notes:   Reports each received byte tagged with its frame number
`timescale 1ns/10ps
`default_nettype none

module scse_flash_model (
  // SPI pins
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sck,
  input  wire logic        spi_mosi,
  output var  logic        spi_miso,
  // Read pattern and receive report
  input  wire logic [7:0]  read_base,
  output var  logic [15:0] rx_word,
  output var  int          rx_count
);
  int         frame = -1;
  int         nbit  = 0;
  int         nbyte = 0;
  logic [7:0] sh    = 8'h00;
  logic [7:0] tx    = 8'h00;

  initial begin
    spi_miso = 1'b0;
    rx_word  = 16'h0000;
    rx_count = 0;
  end

  // New frame on select low
  always @(negedge spi_cs_n) begin
    frame++;
    nbit     = 0;
    nbyte    = 0;
    tx       = read_base;
    spi_miso = tx[7];
  end

  always @(posedge spi_sck) begin
    if (!spi_cs_n) begin
      sh = {sh[6:0], spi_mosi};
      nbit++;
      if (nbit == 8) begin
        rx_word = {8'(frame), sh};
        rx_count++;
        nbit = 0;
        nbyte++;
        tx = read_base + 8'(nbyte);
      end
    end
  end

  always @(negedge spi_sck) begin
    if (!spi_cs_n) begin
      spi_miso = tx[3'(7 - nbit)];
    end
  end

  // Deselected line never holds the last value
  always #7 begin
    if (spi_cs_n !== 1'b0) begin
      spi_miso = ~spi_miso;
    end
  end
endmodule : scse_flash_model

`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the SPI step sequencer
// Assumes: Short millisecond count, flash model on the link
// Notes:   Expected link bytes queued by the driver, popped by a monitor
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import scse_pkg::*;
  localparam int unsigned MS = 4;
  logic        clock = 0;
  logic        reset = 1;
  logic        link_clock = 0;
  logic        step_wr_en = 0;
  logic        step_wr_list = 0;
  logic [4:0]  step_wr_index = 0;
  logic [3:0]  step_wr_op = 0;
  logic [15:0] step_param_a = 0;
  logic [7:0]  step_param_b = 0;
  logic [5:0]  init_step_count = 0;
  logic [5:0]  exit_step_count = 0;
  logic        byte_list_valid = 0;
  logic [7:0]  byte_list_data = 0;
  logic        start_init = 0;
  logic        start_exit = 0;
  logic        programming_done = 0;
  logic [3:0]  buffer_byte_index = 0;
  logic        spi_miso;
  logic        byte_list_ready, busy, done, error;
  logic        spi_cs_n, spi_sck, spi_mosi;
  logic [7:0]  scratch_rd_data, base, flip;
  logic [7:0]  sc [16];
  logic [7:0]  cmd [10] = '{8'h06, 8'h44, 8'h00, 8'h10, 8'h00,
                            8'h48, 8'h00, 8'h10, 8'h00, 8'hFF};
  logic [7:0]  fr [10] = '{0, 1, 1, 1, 1, 2, 2, 2, 2, 2};
  logic [15:0] rx_word;
  logic [15:0] exp_q [$];
  int          rx_count, n;
  int          n_tests = 0;
  int          n_mismatch = 0;
  bit          ok;

  scse_engine #(.MS_COUNT(MS)) scse_engine_inst (
    .clock(clock), .reset(reset), .link_clock(link_clock),
    .step_wr_en(step_wr_en), .step_wr_list(step_wr_list),
    .step_wr_index(step_wr_index), .step_wr_op(step_wr_op),
    .step_param_a(step_param_a), .step_param_b(step_param_b),
    .init_step_count(init_step_count), .exit_step_count(exit_step_count),
    .byte_list_valid(byte_list_valid), .byte_list_ready(byte_list_ready),
    .byte_list_data(byte_list_data), .start_init(start_init),
    .start_exit(start_exit), .programming_done(programming_done),
    .busy(busy), .done(done), .error(error),
    .buffer_byte_index(buffer_byte_index),
    .scratch_rd_data(scratch_rd_data), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  scse_flash_model scse_flash_model_inst (.spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .read_base(base), .rx_word(rx_word), .rx_count(rx_count));

  always #25 clock = ~clock;
  initial begin
    #7;
    forever #15 link_clock = ~link_clock;
  end

  task automatic tick;
    @(posedge clock);
    #2;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic st(input logic l, input logic [4:0] i, input scse_op_e op,
                    input logic [15:0] a, input logic [7:0] b);
    tick;
    step_wr_en    = 1;
    step_wr_list  = l;
    step_wr_index = i;
    step_wr_op    = op;
    step_param_a  = a;
    step_param_b  = b;
  endtask : st

  task automatic push(input logic [7:0] d, input logic [7:0] f,
                      output bit acc);
    tick;
    acc             = byte_list_ready;
    byte_list_valid = acc;
    byte_list_data  = d;
    if (acc) exp_q.push_back({f, d});
  endtask : push

  task automatic wait_done;
    n = 0;
    do begin
      tick;
      n++;
    end while (done !== 1'b1 && n < 20000);
    check(16'(done), 16'h0001);
  endtask : wait_done

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Link byte monitor
  always @(rx_count) begin
    if (rx_count > 0) begin
      check(rx_word, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
    end
  end

  // Gap between erase frame and read frame
  initial begin
    int g;
    g = 0;
    wait (rx_count == 5);
    @(posedge spi_cs_n);
    while (spi_cs_n === 1'b1 && g < 100) begin
      tick;
      g++;
    end
    check(16'(g >= 3 * MS && g <= 40), 16'h0001);
  end

  initial begin
    #1_000_000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(32'he290));
    base = 8'($urandom);
    flip = 8'($urandom);
    repeat (15) @(posedge clock);
    tick;
    reset = 0;
    // Init list: enable, erase, read, modify, write back
    st(0, 0, OP_CS_ON, 0, 0);
    st(0, 1, OP_WRITE, 1, 0);
    st(0, 2, OP_CS_OFF, 0, 0);
    st(0, 3, OP_CS_ON, 0, 0);
    st(0, 4, OP_WRITE, 4, 0);
    st(0, 5, OP_CS_OFF, 0, 0);
    st(0, 6, OP_DELAY, 3, 0);
    st(0, 7, OP_CS_ON, 0, 0);
    st(0, 8, OP_WRITE, 5, 0);
    st(0, 9, OP_VREAD, 0, 16);
    st(0, 10, OP_CS_OFF, 0, 0);
    st(0, 11, OP_VAND, 0, 8'h00);
    st(0, 12, OP_VOR, 0, 8'h12);
    st(0, 13, OP_VXOR, 15, flip);
    st(0, 14, OP_VAND, 6, 8'h00);
    st(0, 15, OP_CS_ON, 0, 0);
    st(0, 16, OP_VWRITE, 0, 16);
    st(0, 17, OP_CS_OFF, 0, 0);
    tick;
    step_wr_en      = 0;
    init_step_count = 6'd18;
    for (int i = 0; i < 10; i++) push(cmd[i], fr[i], ok);
    tick;
    byte_list_valid = 0;
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back(16'h02FF);
      sc[i] = base + 8'(5 + i);
    end
    sc[0]  = 8'h12;
    sc[15] = sc[15] ^ flip;
    sc[6]  = 8'h00;
    for (int i = 0; i < 16; i++) exp_q.push_back({8'h03, sc[i]});
    tick;
    start_init = 1;
    tick;
    start_init = 0;
    wait_done;
    check(16'(error), 16'h0000);
    check(16'(spi_cs_n), 16'h0001);
    check(16'(exp_q.size()), 16'h0000);
    for (int i = 0; i < 16; i++) begin
      tick;
      buffer_byte_index = 4'(i);
      tick;
      check(16'(scratch_rd_data), 16'(sc[i]));
    end
    // Exit refused until programming is done
    tick;
    start_exit = 1;
    tick;
    start_exit = 0;
    check(16'(busy), 16'h0000);
    st(1, 0, OP_CS_ON, 0, 0);
    st(1, 1, OP_WRITE, 32, 0);
    st(1, 2, OP_CS_OFF, 0, 0);
    st(1, 3, OP_VREAD, 10, 8);
    tick;
    step_wr_en      = 0;
    exit_step_count = 6'd4;
    n = 0;
    do begin
      push(8'($urandom), 8'h04, ok);
      n += int'(ok);
    end while (ok && n < 40);
    check(16'(n), 16'h0020);
    check(16'(byte_list_ready), 16'h0000);
    tick;
    programming_done = 1;
    start_exit       = 1;
    tick;
    start_exit = 0;
    wait_done;
    check(16'(error), 16'h0001);
    check(16'(spi_cs_n), 16'h0001);
    check(16'(exp_q.size()), 16'h0000);
    check(16'(byte_list_ready), 16'h0001);
    tally_and_finish;
  end
endmodule : tb_top

`default_nettype wire
